// [src/port3_defs.svh]
/*
 * constants of the port 3 pin block: byte addresses, field masks,
 * reset values and widths.
 * assumes inclusion by bare name from the package and the modules.
 */
`ifndef PORT3_DEFS_SVH
`define PORT3_DEFS_SVH

// ==========================================================
// widths
`define P3_PIN_W              5
`define P3_BUS_W              32
`define P3_REG_W              8
`define P3_SYNC_STAGES        2

// ==========================================================
// byte addresses
`define P3_DRIVE_GATE_ADDR    32'h4002_00c4
`define P3_RESISTOR_EN_ADDR   32'h4002_00c8
`define P3_INPUT_GATE_ADDR    32'h4002_00cc
`define P3_PIN_SAMPLE_ADDR    32'h4002_00d0
`define P3_DRIVE_VALUE_ADDR   32'h4002_00d4
`define P3_DRIVE_HIGH_ADDR    32'h4002_00d8

// ==========================================================
// fields: usable lines at bits 4, 2, 1, 0
`define P3_LINE_MASK          5'h17
`define P3_LINE_ZERO_POS      0
`define P3_LINE_ONE_POS       1
`define P3_LINE_TWO_POS       2
`define P3_LINE_FOUR_POS      4

// ==========================================================
// reset values
`define P3_DRIVE_GATE_RST     5'h00
`define P3_RESISTOR_EN_RST    5'h00
`define P3_INPUT_GATE_RST     5'h00
`define P3_DRIVE_VALUE_RST    5'h00
`define P3_RDATA_RST          32'h0000_0000

`endif

// [src/port3_pkg.sv]
/*
 * types shared by the port 3 pin block.
 * assumes port3_defs.svh is on the include path.
 */
`include "port3_defs.svh"

package port3_pkg;

    // ==========================================================
    // carriers
    typedef logic [`P3_PIN_W-1:0] pin_vec_t;

    typedef struct packed {
        pin_vec_t value;
        pin_vec_t drive;
        pin_vec_t pull;
    } pad_ctrl_t;

    typedef struct packed {
        logic [`P3_BUS_W-1:0] addr;
        logic [`P3_BUS_W-1:0] wdata;
        logic                 wr;
        logic                 rd;
    } bus_req_t;

endpackage

// [src/port3_pin_sync.sv]
/*
 * two-stage synchroniser for the port 3 pins and the gated sample register.
 * assumes pins are asynchronous to i_mclk; gate comes from i_mclk logic.
 */
`timescale 1ns/100ps
`default_nettype none
`include "port3_defs.svh"

module port3_pin_sync
    import port3_pkg::*;
(
    input  wire logic     i_mclk,
    input  wire logic     i_resetn,
    input  wire pin_vec_t i_pin,
    input  wire pin_vec_t i_gate,
    output var  pin_vec_t o_sample
);

    pin_vec_t meta_r;
    pin_vec_t sync_r;

    // ==========================================================
    // synchroniser
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
        end
    end

    // ==========================================================
    // sample register, closed lines read low
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_sample <= '0;
        end else begin
            o_sample <= sync_r & i_gate & `P3_LINE_MASK; // [R4] [R5]
        end
    end

endmodule // port3_pin_sync
`default_nettype wire

// [src/port3_pad_drive.sv]
/*
 * registered pad controls: output level, output enable, pull-up enable.
 * assumes the pad cell resolves the wire from level and enable.
 */
`timescale 1ns/100ps
`default_nettype none
`include "port3_defs.svh"

module port3_pad_drive
    import port3_pkg::*;
(
    input  wire logic      i_mclk,
    input  wire logic      i_resetn,
    input  wire pad_ctrl_t i_ctrl,
    output var  pin_vec_t  o_pin_out,
    output var  pin_vec_t  o_pin_oe,
    output var  pin_vec_t  o_pull_en
);

    // ==========================================================
    // pad registers
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_pin_out <= `P3_DRIVE_VALUE_RST;
            o_pin_oe  <= `P3_DRIVE_GATE_RST;
            o_pull_en <= `P3_RESISTOR_EN_RST;
        end else begin
            o_pin_out <= i_ctrl.value & `P3_LINE_MASK; // [R6]
            o_pin_oe  <= i_ctrl.drive & `P3_LINE_MASK; // [R10]
            o_pull_en <= i_ctrl.pull  & `P3_LINE_MASK; // [R1]
        end
    end

endmodule // port3_pad_drive
`default_nettype wire

// [src/port3_pin_control.sv]
/*
 * port 3 pin block: register file on a plain strobe port, four usable
 * lines at bits 4, 2, 1, 0 with pull-up, input gate, sample, output
 * value, output enable and write-one-to-set.
 * assumes a single-cycle strobe master on i_mclk; pins are asynchronous.
 */
// Summary of operation
// R1: pull-up bit high switches its line's pull-up on, low switches it off.
// R2: pull-up register is zero after reset, no pull-up active.
// R3: software opens a line's input gate before trusting its sampled value.
// R4: input gate bit high connects the line's input path, low disconnects it.
// R5: sample register shows a registered copy of each line's level.
// R6: output value bit drives its line high or low; register reads back.
// R7: output value register is zero after reset.
// R8: writing one to the set register raises that line; zeros change nothing.
// R9: software uses only the normal addresses, never an alias region.
// R10: per-line drive enable decides whether the output value reaches the pin.
// R11: reserved bits 7 to 5 and 3 ignore writes and touch no pin.
`timescale 1ns/100ps
`default_nettype none
`include "port3_defs.svh"

module port3_pin_control
    import port3_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_resetn,
    input  wire logic [`P3_BUS_W-1:0] i_addr,
    input  wire logic [`P3_BUS_W-1:0] i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output var  logic [`P3_BUS_W-1:0] o_rdata,
    input  wire pin_vec_t             i_pin_in,
    output var  pin_vec_t             o_pin_out,
    output var  pin_vec_t             o_pin_oe,
    output var  pin_vec_t             o_pull_en
);

    // ==========================================================
    // helpers
    function automatic logic reg_hit(input bus_req_t r, input logic [`P3_BUS_W-1:0] a);
        reg_hit = (r.addr == a);
    endfunction

    function automatic pin_vec_t line_bits(input logic [`P3_BUS_W-1:0] d);
        line_bits = d[`P3_PIN_W-1:0] & `P3_LINE_MASK;
    endfunction

    function automatic logic [`P3_BUS_W-1:0] widen(input pin_vec_t v);
        widen = {{(`P3_BUS_W-`P3_PIN_W){1'b0}}, v & `P3_LINE_MASK};
    endfunction

    // ==========================================================
    // declarations
    bus_req_t  req;
    pad_ctrl_t pad_ctrl;
    pin_vec_t  drive_gate_r;
    pin_vec_t  resistor_enable_r;
    pin_vec_t  input_gate_r;
    pin_vec_t  drive_value_r;
    pin_vec_t  drive_value_nxt;
    pin_vec_t  pin_sample;
    logic      wr_drive_gate;
    logic      wr_resistor;
    logic      wr_input_gate;
    logic      wr_drive_value;
    logic      wr_drive_high;
    logic [`P3_BUS_W-1:0] rdata_nxt;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // ==========================================================
    // write decode, unmapped and read-only addresses ignore writes
    assign wr_drive_gate  = req.wr && reg_hit(req, `P3_DRIVE_GATE_ADDR);
    assign wr_resistor    = req.wr && reg_hit(req, `P3_RESISTOR_EN_ADDR);
    assign wr_input_gate  = req.wr && reg_hit(req, `P3_INPUT_GATE_ADDR);
    assign wr_drive_value = req.wr && reg_hit(req, `P3_DRIVE_VALUE_ADDR);
    assign wr_drive_high  = req.wr && reg_hit(req, `P3_DRIVE_HIGH_ADDR);

    // ==========================================================
    // pull-up enables
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            resistor_enable_r <= `P3_RESISTOR_EN_RST; // [R2]
        end else if (wr_resistor) begin
            resistor_enable_r <= line_bits(req.wdata); // [R1] [R11]
        end
    end

    // ==========================================================
    // input gates
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            input_gate_r <= `P3_INPUT_GATE_RST;
        end else if (wr_input_gate) begin
            input_gate_r <= line_bits(req.wdata); // [R4] [R11]
        end
    end

    // ==========================================================
    // drive enables
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            drive_gate_r <= `P3_DRIVE_GATE_RST;
        end else if (wr_drive_gate) begin
            drive_gate_r <= line_bits(req.wdata); // [R10] [R11]
        end
    end

    // ==========================================================
    // output value: plain write or write-one-to-set
    always_comb begin
        drive_value_nxt = drive_value_r;
        if (wr_drive_value) begin
            drive_value_nxt = line_bits(req.wdata); // [R6]
        end else if (wr_drive_high) begin
            drive_value_nxt = drive_value_r | line_bits(req.wdata); // [R8]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            drive_value_r <= `P3_DRIVE_VALUE_RST; // [R7]
        end else begin
            drive_value_r <= drive_value_nxt & `P3_LINE_MASK; // [R11]
        end
    end

    // ==========================================================
    // read path, data valid only in the cycle after the strobe
    always_comb begin
        rdata_nxt = `P3_RDATA_RST;
        if (req.rd) begin
            case (req.addr)
                `P3_DRIVE_GATE_ADDR:  rdata_nxt = widen(drive_gate_r);
                `P3_RESISTOR_EN_ADDR: rdata_nxt = widen(resistor_enable_r);
                `P3_INPUT_GATE_ADDR:  rdata_nxt = widen(input_gate_r);
                `P3_PIN_SAMPLE_ADDR:  rdata_nxt = widen(pin_sample); // [R5]
                `P3_DRIVE_VALUE_ADDR: rdata_nxt = widen(drive_value_r); // [R6]
                default:              rdata_nxt = `P3_RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rdata <= `P3_RDATA_RST;
        end else begin
            o_rdata <= rdata_nxt;
        end
    end

    // ==========================================================
    // pin input path
    port3_pin_sync u_pin_sync (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_pin    (i_pin_in),
        .i_gate   (input_gate_r),
        .o_sample (pin_sample)
    );

    // ==========================================================
    // pad controls
    assign pad_ctrl = '{value: drive_value_r, drive: drive_gate_r, pull: resistor_enable_r};

    port3_pad_drive u_pad_drive (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_ctrl    (pad_ctrl),
        .o_pin_out (o_pin_out),
        .o_pin_oe  (o_pin_oe),
        .o_pull_en (o_pull_en)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    sequence s_pull_write;
        wr_resistor;
    endsequence

    sequence s_pin_steady;
        ($stable(i_pin_in & `P3_LINE_MASK) && $stable(input_gate_r))[*4];
    endsequence

    sequence s_set_write;
        wr_drive_high && !wr_drive_value;
    endsequence

    sequence s_value_write;
        wr_drive_value;
    endsequence

    sequence s_gate_write;
        wr_input_gate;
    endsequence

    sequence s_sample_read;
        req.rd && reg_hit(req, `P3_PIN_SAMPLE_ADDR);
    endsequence

    sequence s_strobe_read;
        req.rd && reg_hit(req, `P3_DRIVE_HIGH_ADDR);
    endsequence

    sequence s_refused_write;
        req.wr && reg_hit(req, `P3_PIN_SAMPLE_ADDR);
    endsequence

    // ==========================================================
    // properties

    a_pull_reset_zero: assert property ( // [R2]
        @(posedge i_mclk) disable iff (1'b0)
        $rose(i_resetn) |-> (o_pull_en == '0) && (resistor_enable_r == '0)
    ) else $error("pull-up enabled after reset");

    a_pull_pin_follow: assert property ( // [R1]
        s_pull_write |-> ##2 (o_pull_en == ($past(req.wdata[`P3_PIN_W-1:0], 2) & `P3_LINE_MASK))
    ) else $error("pull-up pin does not follow its register");

    a_gate_blocks_sample: assert property ( // [R4]
        (pin_sample & ~$past(input_gate_r)) == '0
    ) else $error("closed input path shows a level");

    a_sample_tracks_pin: assert property ( // [R5]
        s_pin_steady |-> pin_sample == (i_pin_in & input_gate_r & `P3_LINE_MASK)
    ) else $error("sample register does not match steady pin");

    a_value_write_read: assert property ( // [R6]
        wr_drive_value ##1 (i_rd && reg_hit(req, `P3_DRIVE_VALUE_ADDR) && !i_wr)
        |=> o_rdata == widen($past(req.wdata[`P3_PIN_W-1:0], 2))
    ) else $error("output value does not read back");

    a_value_reset_low: assert property ( // [R7]
        @(posedge i_mclk) disable iff (1'b0)
        $rose(i_resetn) |-> (o_pin_out == '0) && (drive_value_r == '0)
    ) else $error("output value not low after reset");

    a_set_raises_only: assert property ( // [R8]
        s_set_write |=> drive_value_r ==
            (($past(drive_value_r) | $past(req.wdata[`P3_PIN_W-1:0])) & `P3_LINE_MASK)
    ) else $error("set register changed the wrong lines");

    a_drive_gate_pin: assert property ( // [R10]
        o_pin_oe == ($past(drive_gate_r) & `P3_LINE_MASK)
    ) else $error("pin enable does not follow drive enable");

    a_reserved_quiet: assert property ( // [R11]
        ((o_pin_out | o_pin_oe | o_pull_en) & ~`P3_LINE_MASK) == '0
        && o_rdata[`P3_BUS_W-1:`P3_LINE_FOUR_POS+1] == '0
    ) else $error("reserved position reached a pin or read back");

    a_read_one_cycle: assert property (
        !$past(i_rd) |-> o_rdata == `P3_RDATA_RST
    ) else $error("read data outside the answer cycle");

    // ==========================================================
    // register storage and pad follow

    a_value_pin_follow: assert property ( // [R6]
        o_pin_out == ($past(drive_value_r) & `P3_LINE_MASK)
    ) else $error("pin level does not follow output value");

    a_pull_reg_follow: assert property ( // [R1]
        o_pull_en == ($past(resistor_enable_r) & `P3_LINE_MASK)
    ) else $error("pull-up pin does not follow its register bit");

    a_drive_gate_write: assert property ( // [R10] [R11]
        wr_drive_gate |=> drive_gate_r == ($past(req.wdata[`P3_PIN_W-1:0]) & `P3_LINE_MASK)
    ) else $error("drive enable write not stored");

    a_pull_write_stores: assert property ( // [R1] [R11]
        s_pull_write |=> resistor_enable_r == ($past(req.wdata[`P3_PIN_W-1:0]) & `P3_LINE_MASK)
    ) else $error("pull-up write not stored");

    a_gate_reset_closed: assert property ( // [R4]
        @(posedge i_mclk) disable iff (1'b0)
        $rose(i_resetn) |-> (input_gate_r == '0) && (pin_sample == '0)
    ) else $error("input path open after reset");

    a_value_write_stores: assert property ( // [R6] [R11]
        s_value_write |=> drive_value_r == ($past(req.wdata[`P3_PIN_W-1:0]) & `P3_LINE_MASK)
    ) else $error("output value write not stored");

    a_gate_write_stores: assert property ( // [R4] [R11]
        s_gate_write |=> input_gate_r == ($past(req.wdata[`P3_PIN_W-1:0]) & `P3_LINE_MASK)
    ) else $error("input gate write not stored");

    a_sample_read_path: assert property ( // [R5]
        s_sample_read |=> o_rdata == widen($past(pin_sample))
    ) else $error("sample register read differs from sample");

    a_strobe_reads_zero: assert property ( // [R8]
        s_strobe_read |=> o_rdata == `P3_RDATA_RST
    ) else $error("set register read back a value");

    a_sample_write_ignored: assert property ( // [R5]
        s_refused_write |=> $stable(drive_value_r) && $stable(drive_gate_r)
            && $stable(resistor_enable_r) && $stable(input_gate_r)
    ) else $error("write to read-only address changed a register");

endmodule // port3_pin_control
`default_nettype wire

// [testbench/port3_board.sv]
/*
 * board side of the port 3 lines: resolves each wire from the pad drive,
 * the pull-up and an external driver.
 * assumes the bench owns the external driver; no other clock exists.
 */
`timescale 1ns/100ps
`default_nettype none

module port3_board
    import port3_pkg::*;
(
    input  wire logic     i_mclk,
    input  wire pin_vec_t i_pin_out,
    input  wire pin_vec_t i_pin_oe,
    input  wire pin_vec_t i_pull_en,
    input  wire pin_vec_t i_ext_val,
    input  wire pin_vec_t i_ext_en,
    output var  pin_vec_t o_pin_in
);
    // ==========================================================
    // floating lines change every cycle so a stale level never passes
    pin_vec_t wander_r = 5'h00;

    always @(posedge i_mclk) begin
        wander_r <= ~wander_r;
    end

    // ==========================================================
    // wire resolution
    always_comb begin
        for (int i = 0; i < $bits(pin_vec_t); i++) begin
            if (i_pin_oe[i])
                o_pin_in[i] = i_pin_out[i];
            else if (i_ext_en[i])
                o_pin_in[i] = i_ext_val[i];
            else if (i_pull_en[i])
                o_pin_in[i] = 1'b1;
            else
                o_pin_in[i] = wander_r[i];
        end
    end
endmodule // port3_board

`default_nettype wire

// [testbench/test_port3_pin_control.sv]
/*
 * self-checking bench of the port 3 pin block over its strobe port.
 * assumes port3_board on the lines; reset held 20 cycles; 40 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "port3_defs.svh"

module test_port3_pin_control
    import port3_pkg::*;
;
    logic        i_mclk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [31:0] i_addr = 32'h0000_0000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [31:0] o_rdata;
    pin_vec_t    pin_in;
    pin_vec_t    o_pin_out;
    pin_vec_t    o_pin_oe;
    pin_vec_t    o_pull_en;
    pin_vec_t    ext_val = 5'h00;
    pin_vec_t    ext_en = 5'h00;
    int          failures = 0;
    int          comparisons = 0;
    logic [31:0] d;

    always #12.5 i_mclk = ~i_mclk;

    port3_pin_control uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_in), .o_pin_out(o_pin_out),
        .o_pin_oe(o_pin_oe), .o_pull_en(o_pull_en));

    port3_board board (.i_mclk(i_mclk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
        .i_pull_en(o_pull_en), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin_in(pin_in));

    // ==========================================================
    // bus cycles and comparison
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic settle();
        @(posedge i_mclk);
        #1;
    endtask

    // ==========================================================
    // scenarios
    task automatic reset_state();
        rd(`P3_RESISTOR_EN_ADDR);
        check(d, 32'h0000_0000);
        rd(`P3_DRIVE_VALUE_ADDR);
        check(d, 32'h0000_0000);
        check({o_pin_out, o_pin_oe, o_pull_en}, 15'h0000);
    endtask

    task automatic drive_lines();
        wr(`P3_DRIVE_GATE_ADDR, 32'h0000_0017);
        wr(`P3_DRIVE_VALUE_ADDR, 32'h0000_00ff);
        settle();
        check(o_pin_out, 5'h17);
        check(o_pin_oe, 5'h17);
        rd(`P3_DRIVE_VALUE_ADDR);
        check(d, 32'h0000_0017);
        wr(`P3_DRIVE_VALUE_ADDR, 32'h0000_0005);
        wr(`P3_DRIVE_GATE_ADDR, 32'h0000_0003);
        settle();
        check(o_pin_out, 5'h05);
        check(o_pin_oe, 5'h03);
    endtask

    task automatic set_lines();
        wr(`P3_DRIVE_VALUE_ADDR, 32'h0000_0000);
        wr(`P3_DRIVE_HIGH_ADDR, 32'h0000_0012);
        wr(`P3_DRIVE_HIGH_ADDR, 32'h0000_0000);
        settle();
        check(o_pin_out, 5'h12);
        wr(`P3_DRIVE_HIGH_ADDR, 32'h0000_00e9);
        settle();
        check(o_pin_out, 5'h13);
        rd(`P3_DRIVE_HIGH_ADDR);
        check(d, 32'h0000_0000);
    endtask

    task automatic pull_and_sample();
        wr(`P3_DRIVE_GATE_ADDR, 32'h0000_0000);
        ext_en <= 5'h03;
        ext_val <= 5'h01;
        wr(`P3_RESISTOR_EN_ADDR, 32'h0000_00fc);
        settle();
        check(o_pull_en, 5'h14);
        wr(`P3_INPUT_GATE_ADDR, 32'h0000_0000);
        repeat (5) @(posedge i_mclk);
        rd(`P3_PIN_SAMPLE_ADDR);
        check(d, 32'h0000_0000);
        wr(`P3_INPUT_GATE_ADDR, 32'h0000_00ff);
        rd(`P3_INPUT_GATE_ADDR);
        check(d, 32'h0000_0017);
        repeat (5) @(posedge i_mclk);
        rd(`P3_PIN_SAMPLE_ADDR);
        check(d, 32'h0000_0015);
        ext_val <= 5'h02;
        repeat (5) @(posedge i_mclk);
        rd(`P3_PIN_SAMPLE_ADDR);
        check(d, 32'h0000_0016);
        wr(`P3_PIN_SAMPLE_ADDR, 32'h0000_0000);
        rd(32'h4002_00dc);
        check(d, 32'h0000_0000);
    endtask

    task automatic back_to_back();
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= `P3_DRIVE_VALUE_ADDR;
        i_wdata <= 32'h0000_0016;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        i_wr <= 1'b1;
        i_addr <= `P3_DRIVE_HIGH_ADDR;
        i_wdata <= 32'h0000_0001;
        #1;
        check(o_rdata, 32'h0000_0016);
        @(posedge i_mclk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= `P3_DRIVE_VALUE_ADDR;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, 32'h0000_0017);
        check(o_pin_out, 5'h17);
    endtask

    task automatic reset_midrun();
        @(posedge i_mclk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rd(`P3_RESISTOR_EN_ADDR);
        check(d, 32'h0000_0000);
        rd(`P3_DRIVE_VALUE_ADDR);
        check(d, 32'h0000_0000);
        check({o_pin_out, o_pin_oe, o_pull_en}, 15'h0000);
    endtask

    // ==========================================================
    // run and verdict
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge i_mclk);
        i_resetn <= 1'b1;
        reset_state();
        drive_lines();
        set_lines();
        back_to_back();
        pull_and_sample();
        reset_midrun();
        complete_run();
    end

    initial begin
        #(25 * 5000);
        failures++;
        complete_run();
    end
endmodule // test_port3_pin_control

`default_nettype wire
